//--- rtl/sdmia_core.sv
/*
  Sectored data memory with three indirect ports and memory pointers.
  Assumes the core issues at most one operation per clock on a
  synchronous request; read data returns one cycle later.
*/
// Overview of operation
// - 384 general bytes at offsets 80H-FFH of sectors 0, 1 and 2.
// - Every general byte is readable and writable, none protected.
// - Bit set and clear change only the addressed bit.
// - Special area below 80H is the same in every sector, except 40H.
// - Read-only special registers ignore writes.
// - Unused locations below 80H read as 00H.
// - Indirect port access goes to the location held in its pointer.
// - Port zero uses pointer zero and reaches sector 0 only.
// - Ports one and two take sector from high byte, offset from low.
// - Pointer addressing a port reads 00H and writes nothing.
// - Pointers are real registers, read, written, incremented.
// - Direct access reaches every sector via full address.
// - Special area starts at 00H, general area at 80H.
// - Offset 40H is nonvolatile control only in sector 1.
`timescale 1ns/1ps
module sdmia_core
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Request from the core
  input wire sdmia_pkg::sdmia_req_type REQ,
  // Read answer
  output logic [7:0] RDATA,
  output logic RVALID,
  // Read-only status byte seen at the nonvolatile control bits
  input wire logic [7:0] NV_STATUS,
  // Nonvolatile control value for its owner
  output logic [7:0] NV_CONTROL
);

  // Pointer, nonvolatile control and read answer registers
  logic [7:0] pointer_zero, next_pointer_zero;
  logic [7:0] pointer_one_low, next_pointer_one_low;
  logic [7:0] pointer_one_sector, next_pointer_one_sector;
  logic [7:0] pointer_two_low, next_pointer_two_low;
  logic [7:0] pointer_two_sector, next_pointer_two_sector;
  logic [7:0] nonvolatile_control, next_nonvolatile_control;
  logic [7:0] rdata_q, next_rdata;
  logic rvalid_q, next_rvalid;

  sdmia_pkg::sdmia_tgt_type tgt;
  logic [7:0] cur;
  logic [7:0] newv;
  logic does_write;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic is_gp;
  logic [7:0] bit_mask;

  // Resolve indirect ports to their physical target
  always_comb
  begin
    tgt.valid = 1'b1;
    tgt.sector = REQ.sector;
    tgt.offset = REQ.offset;
    case (REQ.offset)
      sdmia_pkg::OFS_PORT0:
      begin
        tgt.sector = sdmia_pkg::SECT_0;
        tgt.offset = pointer_zero;
      end
      sdmia_pkg::OFS_PORT1:
      begin
        tgt.sector = pointer_one_sector[1:0];
        tgt.offset = pointer_one_low;
        tgt.valid = (pointer_one_sector <= sdmia_pkg::SECT_MAX);
      end
      sdmia_pkg::OFS_PORT2:
      begin
        tgt.sector = pointer_two_sector[1:0];
        tgt.offset = pointer_two_low;
        tgt.valid = (pointer_two_sector <= sdmia_pkg::SECT_MAX);
      end
      default:
      begin
        tgt.valid = (REQ.sector <= sdmia_pkg::SECT_2);
      end
    endcase
    // A pointer aimed at a port yields no storage at all
    if (tgt.offset == sdmia_pkg::OFS_PORT0 ||
        tgt.offset == sdmia_pkg::OFS_PORT1 ||
        tgt.offset == sdmia_pkg::OFS_PORT2)
    begin
      tgt.valid = 1'b0;
    end
  end

  // General area is the top half of every sector
  assign is_gp = tgt.offset[sdmia_pkg::GP_BIT];
  assign bit_mask = sdmia_pkg::VAL_ONE << REQ.bit_sel;

  // Current value of the target; special area ignores the sector except at 40H
  always_comb
  begin
    cur = sdmia_pkg::VAL_ZERO;
    if (tgt.valid)
    begin
      if (is_gp)
      begin
        cur = ram_rdata;
      end
      else
      begin
        case (tgt.offset)
          sdmia_pkg::OFS_PTR0: cur = pointer_zero;
          sdmia_pkg::OFS_PTR1_LOW: cur = pointer_one_low;
          sdmia_pkg::OFS_PTR1_SECT: cur = pointer_one_sector;
          sdmia_pkg::OFS_PTR2_LOW: cur = pointer_two_low;
          sdmia_pkg::OFS_PTR2_SECT: cur = pointer_two_sector;
          sdmia_pkg::OFS_NV_CTRL:
          begin
            if (tgt.sector == sdmia_pkg::SECT_1)
            begin
              cur = nonvolatile_control | NV_STATUS;
            end
          end
          default: cur = sdmia_pkg::VAL_ZERO;
        endcase
      end
    end
  end

  // New value for modifying operations
  always_comb
  begin
    newv = cur;
    does_write = tgt.valid;
    case (REQ.op)
      sdmia_pkg::OP_WRITE: newv = REQ.wdata;
      sdmia_pkg::OP_BSET: newv = cur | bit_mask;
      sdmia_pkg::OP_BCLR: newv = cur & ~bit_mask;
      sdmia_pkg::OP_INC: newv = cur + sdmia_pkg::VAL_ONE;
      sdmia_pkg::OP_DEC: newv = cur - sdmia_pkg::VAL_ONE;
      default: does_write = 1'b0;
    endcase
  end

  assign ram_we = does_write && is_gp;

  // Storage for the general area
  sdmia_gp_ram u_ram
  (
    .clk(CLK_SYS),
    .we(ram_we),
    .sector(tgt.sector),
    .index(tgt.offset[sdmia_pkg::GP_IDX_W-1:0]),
    .wdata(newv),
    .rdata(ram_rdata)
  );

  // Next values of the special registers and read answer
  always_comb
  begin
    next_pointer_zero = pointer_zero;
    next_pointer_one_low = pointer_one_low;
    next_pointer_one_sector = pointer_one_sector;
    next_pointer_two_low = pointer_two_low;
    next_pointer_two_sector = pointer_two_sector;
    next_nonvolatile_control = nonvolatile_control;
    next_rdata = rdata_q;
    next_rvalid = (REQ.op == sdmia_pkg::OP_READ);
    if (REQ.op == sdmia_pkg::OP_READ)
    begin
      next_rdata = cur;
    end
    if (does_write && !is_gp)
    begin
      case (tgt.offset)
        sdmia_pkg::OFS_PTR0: next_pointer_zero = newv;
        sdmia_pkg::OFS_PTR1_LOW: next_pointer_one_low = newv;
        sdmia_pkg::OFS_PTR1_SECT: next_pointer_one_sector = newv;
        sdmia_pkg::OFS_PTR2_LOW: next_pointer_two_low = newv;
        sdmia_pkg::OFS_PTR2_SECT: next_pointer_two_sector = newv;
        sdmia_pkg::OFS_NV_CTRL:
        begin
          // Status bits are read-only; only the stored part takes data
          if (tgt.sector == sdmia_pkg::SECT_1)
          begin
            next_nonvolatile_control = newv & ~NV_STATUS;
          end
        end
        default: next_rdata = next_rdata; // Unused: write dropped
      endcase
    end
  end

  // Register stage; pointers reset to zero for a defined start
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      pointer_zero <= sdmia_pkg::VAL_ZERO;
      pointer_one_low <= sdmia_pkg::VAL_ZERO;
      pointer_one_sector <= sdmia_pkg::VAL_ZERO;
      pointer_two_low <= sdmia_pkg::VAL_ZERO;
      pointer_two_sector <= sdmia_pkg::VAL_ZERO;
      nonvolatile_control <= sdmia_pkg::VAL_ZERO;
      rdata_q <= sdmia_pkg::VAL_ZERO;
      rvalid_q <= 1'b0;
    end
    else
    begin
      pointer_zero <= next_pointer_zero;
      pointer_one_low <= next_pointer_one_low;
      pointer_one_sector <= next_pointer_one_sector;
      pointer_two_low <= next_pointer_two_low;
      pointer_two_sector <= next_pointer_two_sector;
      nonvolatile_control <= next_nonvolatile_control;
      rdata_q <= next_rdata;
      rvalid_q <= next_rvalid;
    end
  end

  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;
  assign NV_CONTROL = nonvolatile_control;

  // Checks. Antecedents that need a direct request to take effect keep to sectors 0 to 2,
  // since a direct request naming sector 3 is dropped by choice.
  sequence s_wr_ptr0;
    REQ.op == sdmia_pkg::OP_WRITE && REQ.offset == sdmia_pkg::OFS_PTR0
    && REQ.sector <= sdmia_pkg::SECT_2;
  endsequence

  sequence s_read_any;
    REQ.op == sdmia_pkg::OP_READ;
  endsequence

  // Stored control written where it exists
  sequence s_wr_nv_own;
    REQ.op == sdmia_pkg::OP_WRITE && REQ.offset == sdmia_pkg::OFS_NV_CTRL
    && REQ.sector == sdmia_pkg::SECT_1;
  endsequence

  // Write through port one while its pointer names a port
  sequence s_port1_self;
    REQ.op == sdmia_pkg::OP_WRITE && REQ.offset == sdmia_pkg::OFS_PORT1
    && (pointer_one_low == sdmia_pkg::OFS_PORT0
    || pointer_one_low == sdmia_pkg::OFS_PORT1
    || pointer_one_low == sdmia_pkg::OFS_PORT2);
  endsequence

  // Direct read of pointer zero from a decoded sector
  sequence s_rd_ptr0;
    REQ.op == sdmia_pkg::OP_READ && REQ.offset == sdmia_pkg::OFS_PTR0
    && REQ.sector <= sdmia_pkg::SECT_2;
  endsequence

  AST_PTR0_WRITE: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B) s_wr_ptr0 |=> pointer_zero == $past(REQ.wdata))
    else $error("pointer zero write lost");
  AST_PORT0_SECT: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    REQ.offset == sdmia_pkg::OFS_PORT0 |-> tgt.sector == sdmia_pkg::SECT_0)
    else $error("port zero left sector 0");
  AST_PORT_SELF: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_READ && REQ.offset == sdmia_pkg::OFS_PORT0
     && pointer_zero == sdmia_pkg::OFS_PORT1)
    |=> RDATA == sdmia_pkg::VAL_ZERO)
    else $error("self indirect read not zero");
  AST_UNUSED_ZERO: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_READ && REQ.offset == 8'h0f)
    |=> RVALID && RDATA == sdmia_pkg::VAL_ZERO)
    else $error("unused location not zero");
  AST_BAD_SECT: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.offset == sdmia_pkg::OFS_PORT1
     && pointer_one_sector > sdmia_pkg::SECT_MAX) |-> !ram_we)
    else $error("bad sector wrote");
  AST_NV_SECT: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_WRITE && REQ.offset == sdmia_pkg::OFS_NV_CTRL
     && REQ.sector != sdmia_pkg::SECT_1) |=> $stable(nonvolatile_control))
    else $error("control changed outside sector 1");
  AST_GP_RW: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_WRITE && REQ.offset[sdmia_pkg::GP_BIT]
     && REQ.sector <= sdmia_pkg::SECT_2) |-> ram_we)
    else $error("general write dropped");
  AST_INC: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_INC && REQ.offset == sdmia_pkg::OFS_PTR1_LOW
     && REQ.sector <= sdmia_pkg::SECT_2)
    |=> pointer_one_low == $past(pointer_one_low) + sdmia_pkg::VAL_ONE)
    else $error("pointer increment wrong");
  AST_BIT: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_BSET && REQ.offset == sdmia_pkg::OFS_PTR2_LOW
     && REQ.sector <= sdmia_pkg::SECT_2)
    |=> pointer_two_low == ($past(pointer_two_low) | $past(bit_mask)))
    else $error("bit set touched other bits");
  AST_SECT_MIRROR: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_WRITE && REQ.offset == sdmia_pkg::OFS_PTR2_SECT
     && REQ.sector == sdmia_pkg::SECT_2)
    |=> pointer_two_sector == $past(REQ.wdata))
    else $error("special area not mirrored");

  // Read answer: one valid pulse per read, none otherwise
  AST_READ_VALID: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B) s_read_any |=> RVALID)
    else $error("read not answered");
  AST_NO_STRAY: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B) REQ.op != sdmia_pkg::OP_READ |=> !RVALID)
    else $error("valid without a read");
  AST_SELF_WR: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B) s_port1_self |-> !does_write)
    else $error("write through self pointer");
  AST_RO_KEEP: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    s_wr_nv_own |=> (nonvolatile_control & $past(NV_STATUS))
    == sdmia_pkg::VAL_ZERO)
    else $error("read-only status bits stored");
  AST_MIRROR_RD: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B) s_rd_ptr0 |=> RDATA == $past(pointer_zero))
    else $error("pointer zero differs by sector");
  AST_DEC: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_DEC && REQ.offset == sdmia_pkg::OFS_PTR0
     && REQ.sector <= sdmia_pkg::SECT_2)
    |=> pointer_zero == $past(pointer_zero) - sdmia_pkg::VAL_ONE)
    else $error("pointer decrement wrong");
  AST_BCLR: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_BCLR && REQ.offset == sdmia_pkg::OFS_PTR2_LOW
     && REQ.sector <= sdmia_pkg::SECT_2)
    |=> pointer_two_low == ($past(pointer_two_low) & ~$past(bit_mask)))
    else $error("bit clear touched other bits");
  AST_NV_OTHER_RD: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_READ && REQ.offset == sdmia_pkg::OFS_NV_CTRL
     && REQ.sector != sdmia_pkg::SECT_1) |=> RDATA == sdmia_pkg::VAL_ZERO)
    else $error("control visible outside sector 1");
  AST_DIRECT_BAD: assert property (@(posedge CLK_SYS)
    disable iff (!RST_B)
    (REQ.op == sdmia_pkg::OP_READ && REQ.offset[sdmia_pkg::GP_BIT]
     && REQ.sector > sdmia_pkg::SECT_2) |=> RDATA == sdmia_pkg::VAL_ZERO)
    else $error("undecoded sector read not zero");

endmodule : sdmia_core

//--- rtl/sdmia_gp_ram.sv
/*
  General purpose storage: three sectors of 128 bytes each.
  Assumes the caller gives a legal sector and one access per cycle.
*/
`timescale 1ns/1ps
module sdmia_gp_ram
(
  // Clock
  input wire logic clk,
  // Access
  input wire logic we,
  input wire logic [1:0] sector,
  input wire logic [6:0] index,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:sdmia_pkg::NUM_SECT*sdmia_pkg::GP_WORDS-1];
  logic [8:0] addr;

  // Flat address; no reset so the array maps onto RAM cells
  assign addr = {sector, index};
  assign rdata = mem[addr];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

endmodule : sdmia_gp_ram

//--- rtl/sdmia_pkg.sv
/*
  Package for the sectored data memory block: map offsets, sector
  numbers, operation codes and the access request carrier.
  Assumes a single 8-bit data path driven by the processor core.
*/
package sdmia_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SECT_W = 2;
  localparam int unsigned NUM_SECT = 3;
  localparam int unsigned GP_WORDS = 128;
  localparam int unsigned GP_IDX_W = 7;

  // Map offsets
  localparam logic [7:0] OFS_PORT0 = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h01;
  localparam logic [7:0] OFS_PORT1 = 8'h02;
  localparam logic [7:0] OFS_PTR1_LOW = 8'h03;
  localparam logic [7:0] OFS_PTR1_SECT = 8'h04;
  localparam logic [7:0] OFS_PORT2 = 8'h0c;
  localparam logic [7:0] OFS_PTR2_LOW = 8'h0d;
  localparam logic [7:0] OFS_PTR2_SECT = 8'h0e;
  localparam logic [7:0] OFS_NV_CTRL = 8'h40;
  localparam logic [7:0] OFS_GP_BASE = 8'h80;
  localparam int unsigned GP_BIT = 7;

  // Sector numbers
  localparam logic [1:0] SECT_0 = 2'h0;
  localparam logic [1:0] SECT_1 = 2'h1;
  localparam logic [1:0] SECT_2 = 2'h2;
  localparam logic [7:0] SECT_MAX = 8'h02;

  // Reset and constant values
  localparam logic [7:0] VAL_ZERO = 8'h00;
  localparam logic [7:0] VAL_ONE = 8'h01;

  // Operation codes issued by the core
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_BSET = 3'b011,
    OP_BCLR = 3'b100,
    OP_INC = 3'b101,
    OP_DEC = 3'b110
  } sdmia_op_type;

  // Address selection: direct uses the full address, or an indirect port
  typedef struct packed {
    sdmia_op_type op;
    logic [1:0] sector;
    logic [7:0] offset;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } sdmia_req_type;

  // Resolved physical target
  typedef struct packed {
    logic valid;
    logic [1:0] sector;
    logic [7:0] offset;
  } sdmia_tgt_type;

endpackage : sdmia_pkg

//--- verif/sdmia_cpu_model.sv
/*
  Processor core model: issues one data memory operation per clock.
  Assumes the memory takes a request at every rising edge of clk.
*/
`timescale 1ns/1ps
module sdmia_cpu_model
(
  // Clock
  input wire logic clk,
  // Request to the memory
  output sdmia_pkg::sdmia_req_type req
);
  // Idle until the first operation is issued
  initial req = '0;

  // Drive just after the edge and hold one full cycle; calls run back to back
  task automatic issue(input sdmia_pkg::sdmia_op_type op,
    input logic [1:0] sect, input logic [7:0] ofs, input logic [2:0] bsel,
    input logic [7:0] wd);
    @(posedge clk);
    req <= '{op, sect, ofs, bsel, wd};
  endtask : issue
endmodule : sdmia_cpu_model

//--- verif/sectored_data_memory_indirect_access_test.sv
/*
  Self-checking bench for the sectored data memory: direct, bit,
  indirect, pointer and nonvolatile control accesses.
  Assumes read data arrives with a one-cycle valid pulse.
*/
`timescale 1ns/1ps
module sectored_data_memory_indirect_access_test;
  localparam int cyc_limit = 3000;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] nv_status = 8'h00;
  logic [7:0] rdata;
  logic [7:0] nv_control;
  logic rvalid;
  sdmia_pkg::sdmia_req_type req;
  logic [7:0] exp_q[$];
  logic [7:0] dv[3];
  logic [7:0] d;
  logic [7:0] ns;
  logic [7:0] kept;
  integer seed = 58;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  // 50 MHz clock
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  sdmia_cpu_model u_cpu (.clk(clk_sys), .req(req));

  sdmia_core u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .REQ(req),
    .RDATA(rdata), .RVALID(rvalid), .NV_STATUS(nv_status),
    .NV_CONTROL(nv_control));

  task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp || $isunknown(seen))
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic give_verdict();
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic wr(input int s, input logic [7:0] a,
    input logic [7:0] v);
    u_cpu.issue(sdmia_pkg::OP_WRITE, 2'(s), a, 3'h0, v);
  endtask : wr

  // The note goes in before the read, so the watcher always finds it
  task automatic rd(input int s, input logic [7:0] a,
    input logic [7:0] e);
    exp_q.push_back(e);
    u_cpu.issue(sdmia_pkg::OP_READ, 2'(s), a, 3'h0, 8'h00);
  endtask : rd

  task automatic op(input sdmia_pkg::sdmia_op_type o, input int s,
    input logic [7:0] a, input logic [2:0] b);
    u_cpu.issue(o, 2'(s), a, b, 8'h00);
  endtask : op

  // Watcher: sampled mid-cycle, away from the launching edge
  always @(negedge clk_sys)
  begin
    if (rvalid === 1'b1)
      check_val(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == cyc_limit)
    begin
      err_total++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(0, sdmia_pkg::OFS_PTR0, 8'h00);
    // Same offset in each sector holds its own byte, plus both bounds
    for (int s = 0; s < 3; s++)
    begin
      dv[s] = 8'($random(seed));
      wr(s[1:0], 8'ha5, dv[s]);
      d = 8'($random(seed));
      wr(s[1:0], 8'h80, d);
      rd(s[1:0], 8'h80, d);
      wr(s[1:0], 8'hff, ~d);
      rd(s[1:0], 8'hff, ~d);
    end
    for (int s = 0; s < 3; s++)
      rd(s[1:0], 8'ha5, dv[s]);
    rd(2'h3, 8'ha5, 8'h00);
    // Bit set and clear touch one bit only
    wr(1, 8'hc0, 8'h5a);
    op(sdmia_pkg::OP_BSET, 1, 8'hc0, 3'h0);
    op(sdmia_pkg::OP_BSET, 1, 8'hc0, 3'h1);
    op(sdmia_pkg::OP_BCLR, 1, 8'hc0, 3'h6);
    op(sdmia_pkg::OP_BCLR, 1, 8'hc0, 3'h2);
    rd(1, 8'hc0, 8'h1b);
    // Pointer zero written in sector 2, seen from sectors 0 and 1
    wr(0, 8'h90, 8'h11);
    wr(1, 8'h90, 8'h22);
    wr(2, sdmia_pkg::OFS_PTR0, 8'h90);
    rd(0, sdmia_pkg::OFS_PTR0, 8'h90);
    rd(1, sdmia_pkg::OFS_PTR0, 8'h90);
    wr(2, sdmia_pkg::OFS_PORT0, 8'h33);
    rd(0, 8'h90, 8'h33);
    rd(1, 8'h90, 8'h22);
    rd(1, sdmia_pkg::OFS_PORT0, 8'h33);
    // Ports one and two take their sector from the pointer high byte
    wr(0, sdmia_pkg::OFS_PTR1_SECT, 8'h02);
    wr(0, sdmia_pkg::OFS_PTR1_LOW, 8'ha0);
    wr(0, sdmia_pkg::OFS_PTR2_SECT, 8'h01);
    wr(0, sdmia_pkg::OFS_PTR2_LOW, 8'ha0);
    wr(0, sdmia_pkg::OFS_PORT1, 8'h44);
    wr(0, sdmia_pkg::OFS_PORT2, 8'h55);
    rd(2, 8'ha0, 8'h44);
    rd(1, 8'ha0, 8'h55);
    rd(0, sdmia_pkg::OFS_PORT2, 8'h55);
    // Pointer aimed at a port: reads zero, writes dropped
    wr(0, sdmia_pkg::OFS_PTR1_SECT, 8'h00);
    wr(0, sdmia_pkg::OFS_PTR1_LOW, sdmia_pkg::OFS_PORT2);
    rd(0, sdmia_pkg::OFS_PORT1, 8'h00);
    wr(0, sdmia_pkg::OFS_PORT1, 8'h66);
    wr(0, sdmia_pkg::OFS_PTR1_LOW, sdmia_pkg::OFS_PORT0);
    wr(0, sdmia_pkg::OFS_PORT1, 8'h77);
    rd(1, 8'ha0, 8'h55);
    rd(0, 8'h90, 8'h33);
    // Sector value out of range
    wr(0, sdmia_pkg::OFS_PTR1_SECT, 8'h03);
    wr(0, sdmia_pkg::OFS_PTR1_LOW, 8'ha0);
    wr(0, sdmia_pkg::OFS_PORT1, 8'h88);
    rd(0, sdmia_pkg::OFS_PORT1, 8'h00);
    rd(1, sdmia_pkg::OFS_PTR1_SECT, 8'h03);
    rd(2, 8'ha0, 8'h44);
    // Pointer increment, decrement and wrap
    op(sdmia_pkg::OP_INC, 0, sdmia_pkg::OFS_PTR0, 3'h0);
    rd(0, sdmia_pkg::OFS_PTR0, 8'h91);
    op(sdmia_pkg::OP_DEC, 0, sdmia_pkg::OFS_PTR0, 3'h0);
    op(sdmia_pkg::OP_DEC, 2, sdmia_pkg::OFS_PTR0, 3'h0);
    rd(1, sdmia_pkg::OFS_PTR0, 8'h8f);
    wr(0, sdmia_pkg::OFS_PTR2_LOW, 8'hff);
    op(sdmia_pkg::OP_INC, 0, sdmia_pkg::OFS_PTR2_LOW, 3'h0);
    rd(0, sdmia_pkg::OFS_PTR2_LOW, 8'h00);
    // Unused low offsets read zero even after a write
    foreach (dv[s])
    begin
      wr(s[1:0], 8'h0f, 8'hff);
      rd(s[1:0], 8'h0f, 8'h00);
      wr(s[1:0], 8'h7f, 8'hff);
      rd(s[1:0], 8'h7f, 8'h00);
    end
    // Pointer byte updates seen from other sectors
    wr(2, sdmia_pkg::OFS_PTR2_SECT, 8'h02);
    rd(0, sdmia_pkg::OFS_PTR2_SECT, 8'h02);
    op(sdmia_pkg::OP_INC, 1, sdmia_pkg::OFS_PTR1_LOW, 3'h0);
    rd(2, sdmia_pkg::OFS_PTR1_LOW, 8'ha1);
    op(sdmia_pkg::OP_BSET, 0, sdmia_pkg::OFS_PTR2_LOW, 3'h3);
    rd(1, sdmia_pkg::OFS_PTR2_LOW, 8'h08);
    op(sdmia_pkg::OP_BCLR, 2, sdmia_pkg::OFS_PTR2_LOW, 3'h3);
    rd(0, sdmia_pkg::OFS_PTR2_LOW, 8'h00);
    // Pointer zero aimed at port one reads zero
    wr(0, sdmia_pkg::OFS_PTR0, sdmia_pkg::OFS_PORT1);
    rd(0, sdmia_pkg::OFS_PORT0, 8'h00);
    // Nonvolatile control: sector 1 only, status bits read-only
    ns = 8'($random(seed));
    d = 8'($random(seed));
    nv_status <= ns;
    kept = d & ~ns;
    wr(1, sdmia_pkg::OFS_NV_CTRL, d);
    wr(0, sdmia_pkg::OFS_NV_CTRL, 8'hff);
    wr(2, sdmia_pkg::OFS_NV_CTRL, 8'hff);
    rd(1, sdmia_pkg::OFS_NV_CTRL, kept | ns);
    rd(0, sdmia_pkg::OFS_NV_CTRL, 8'h00);
    rd(2, sdmia_pkg::OFS_NV_CTRL, 8'h00);
    op(sdmia_pkg::OP_NONE, 0, 8'h00, 3'h0);
    repeat (3) @(negedge clk_sys);
    check_val(nv_control, kept);
    check_val(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule : sectored_data_memory_indirect_access_test
